/* File: logic/dcbstl_engine.sv */
// Data-cache block store, touch and lock engine with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module dcbstl_engine
  import dcbstl_pkg::*;
#(
  parameter int WAYS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pipeline request
  input wire logic req_valid,
  output logic req_ready,
  input wire dcbstl_req_t req,
  // Cache lookup result for the request address
  input wire logic line_hit,
  input wire logic line_dirty,
  input wire logic [WAYS-1:0] way_locked,
  input wire logic [WAYS-1:0] way_valid,
  // Cache command out
  output dcbstl_cmd_t cmd,
  output logic [WAYS-1:0] cmd_way,
  input wire logic cmd_done,
  // Fault report
  output logic storage_fault,
  // Interrupt
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // Elaboration check on the way count
  if (WAYS < 1 || WAYS > 32) begin
    $error("WAYS out of range");
  end

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUSY = 2'b01,
    S_WAIT = 2'b11
  } dcbstl_state_t;

  typedef struct packed {
    dcbstl_state_t state;
    dcbstl_cmd_t cmd;
    logic [WAYS-1:0] way;
    logic fault;
    logic [31:0] ctrl;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcbstl_regs_t;

  dcbstl_regs_t r_reg, r_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [WAYS-1:0] first_set(input logic [WAYS-1:0] v);
    logic [WAYS-1:0] res;
    res = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = '0;
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction

  logic [63:0] effective_address;
  logic [63:0] base_val;
  logic accept;
  logic is_touch;
  logic is_lock;
  logic target_ok;
  logic secondary;
  logic cache_on;
  logic unable;
  logic all_locked;
  logic allow;
  logic [WAYS-1:0] victim;
  logic [ST_W-1:0] ev;
  logic wr_fire;
  logic [31:0] wmask;

  always_comb begin
    base_val = req.base_zero ? 64'h0 : req.base;
    effective_address = base_val + req.index;
    if (r_reg.ctrl[CTRL_M32]) begin
      effective_address[63:32] = 32'h0;
    end
  end

  assign req_ready = (r_reg.state == S_IDLE);
  assign accept = req_valid && req_ready;
  assign is_touch = (req.op == OP_TOUCH) || (req.op == OP_TOUCH_ST);
  assign is_lock = (req.op == OP_LOCK) || (req.op == OP_LOCK_ST);
  assign secondary = (req.cache_target_field == TARGET_SECONDARY);
  // Secondary target accepted for every form except OP_LOCK
  assign target_ok = (req.cache_target_field == TARGET_PRIMARY) ||
    (secondary && req.op != OP_LOCK);
  assign cache_on = secondary ? r_reg.ctrl[CTRL_L2EN] : r_reg.ctrl[CTRL_L1EN];
  assign unable = req.inhibited || !req.lock_capable || !cache_on ||
    !target_ok;
  assign all_locked = &way_locked;
  assign allow = secondary ? r_reg.ctrl[CTRL_L2OLA] :
    r_reg.ctrl[CTRL_OLA];
  // Victim: empty way, else unlocked way, else a locked way when allowed
  assign victim = (|(~way_valid)) ? first_set(~way_valid) :
    (!all_locked ? first_set(~way_locked) :
    first_set(way_locked));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_next = r_reg;
    ev = '0;
    wr_fire = 1'b0;
    wmask = '0;
    r_next.fault = 1'b0;

    case (r_reg.state)
      S_IDLE: begin
        if (accept) begin
          r_next.cmd = '0;
          r_next.cmd.addr = effective_address;
          r_next.cmd.level = req.cache_target_field;
          r_next.way = '0;
          case (req.op)
            OP_STORE: begin
              if (req.xlate_fault) begin
                r_next.fault = 1'b1;
              end else begin
                // Same path regardless of inhibited or write-through
                r_next.cmd.valid = 1'b1;
                r_next.cmd.level = TARGET_PRIMARY;
                r_next.cmd.writeback = 1'b1;
                r_next.cmd.broadcast = req.coherent &&
                  r_reg.ctrl[CTRL_BCAST];
              end
            end
            OP_TOUCH, OP_TOUCH_ST: begin
              // Dropped silently on fault, inhibit or bad target
              if (!req.xlate_fault && !req.inhibited && target_ok &&
                  cache_on && !line_hit) begin
                r_next.cmd.valid = 1'b1;
                r_next.cmd.fetch = 1'b1;
                r_next.way = victim;
                r_next.cmd.evict_locked = 1'b0;
              end
              if (all_locked && !line_hit) begin
                r_next.cmd.valid = 1'b0;
              end
            end
            OP_LOCK, OP_LOCK_ST: begin
              if (req.xlate_fault) begin
                r_next.fault = 1'b1;
              end else if (unable) begin
                ev[ST_UL] = 1'b1;
              end else if (!line_hit && all_locked && !allow) begin
                ev[secondary ? ST_L2OL : ST_OL] = 1'b1;
              end else begin
                r_next.cmd.valid = 1'b1;
                r_next.cmd.lock = 1'b1;
                r_next.cmd.fetch = !line_hit;
                r_next.way = line_hit ? '0 : victim;
                if (!line_hit && all_locked) begin
                  r_next.cmd.evict_locked = 1'b1;
                  ev[secondary ? ST_L2OL : ST_OL] = 1'b1;
                end
              end
            end
            default: begin
              r_next.cmd.valid = 1'b0;
            end
          endcase
          if (r_next.cmd.valid) begin
            r_next.state = S_BUSY;
          end else begin
            ev[ST_DONE] = 1'b1;
          end
        end
      end
      S_BUSY: begin
        if (cmd_done) begin
          r_next.cmd.valid = 1'b0;
          r_next.state = S_WAIT;
        end
      end
      S_WAIT: begin
        ev[ST_DONE] = 1'b1;
        r_next.state = S_IDLE;
      end
      default: begin
        r_next.state = S_IDLE;
      end
    endcase

    // AXI write address and data, either order
    if (s_awvalid && !r_reg.aw_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_awaddr;
    end
    if (s_wvalid && !r_reg.w_got && !r_reg.bvalid) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_wdata;
      r_next.wstrb = s_wstrb;
    end
    if (r_reg.aw_got && r_reg.w_got) begin
      wr_fire = 1'b1;
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        wmask[b*8 +: 8] = {8{r_reg.wstrb[b]}};
      end
      case ({r_reg.awaddr[7:2], 2'b00})
        OFF_CTRL: r_next.ctrl = (r_reg.ctrl & ~wmask) |
          (r_reg.wdata & wmask);
        OFF_STAT: begin
        end
        OFF_MASK: r_next.mask = (r_reg.mask & ~wmask[ST_W-1:0]) |
          (r_reg.wdata[ST_W-1:0] & wmask[ST_W-1:0]);
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_bready) begin
      r_next.bvalid = 1'b0;
    end

    // Status: write one clears, new event wins
    r_next.stat = r_reg.stat;
    if (wr_fire && {r_reg.awaddr[7:2], 2'b00} == OFF_STAT) begin
      r_next.stat = r_reg.stat &
        ~(r_reg.wdata[ST_W-1:0] & wmask[ST_W-1:0]);
    end
    r_next.stat = r_next.stat | ev;

    // AXI read
    if (s_arvalid && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.rdata = '0;
      case ({s_araddr[7:2], 2'b00})
        OFF_CTRL: r_next.rdata = r_reg.ctrl;
        OFF_STAT: r_next.rdata[ST_W-1:0] = r_reg.stat;
        OFF_MASK: r_next.rdata[ST_W-1:0] = r_reg.mask;
        default: r_next.rresp = RESP_SLVERR;
      endcase
    end else if (r_reg.rvalid && s_rready) begin
      r_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.ctrl <= CTRL_RST;
      r_reg.state <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd = r_reg.cmd;
  assign cmd_way = r_reg.way;
  assign storage_fault = r_reg.fault;
  assign irq = |(r_reg.stat & r_reg.mask);
  assign s_awready = !r_reg.aw_got && !r_reg.bvalid;
  assign s_wready = !r_reg.w_got && !r_reg.bvalid;
  assign s_bvalid = r_reg.bvalid;
  assign s_bresp = r_reg.bresp;
  assign s_arready = !r_reg.rvalid;
  assign s_rvalid = r_reg.rvalid;
  assign s_rdata = r_reg.rdata;
  assign s_rresp = r_reg.rresp;

endmodule
`default_nettype wire

/* File: logic/dcbstl_pkg.sv */
// Package for the data-cache block store, touch and lock engine
package dcbstl_pkg;
  // Operation codes from the pipeline
  typedef enum logic [2:0] {
    OP_STORE = 3'h0,
    OP_TOUCH = 3'h1,
    OP_TOUCH_ST = 3'h2,
    OP_LOCK = 3'h3,
    OP_LOCK_ST = 3'h4
  } dcbstl_op_t;

  localparam logic [1:0] TARGET_PRIMARY = 2'h0;
  localparam logic [1:0] TARGET_SECONDARY = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;

  // Control register bits
  localparam int CTRL_OLA = 0;
  localparam int CTRL_L2OLA = 1;
  localparam int CTRL_BCAST = 2;
  localparam int CTRL_L1EN = 3;
  localparam int CTRL_L2EN = 4;
  localparam int CTRL_M32 = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0038;

  // Status bits
  localparam int ST_UL = 0;
  localparam int ST_OL = 1;
  localparam int ST_L2OL = 2;
  localparam int ST_DONE = 3;
  localparam int ST_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Request from the pipeline
  typedef struct packed {
    dcbstl_op_t op;
    logic [1:0] cache_target_field;
    logic base_zero;
    logic [63:0] base;
    logic [63:0] index;
    logic inhibited;
    logic coherent;
    logic lock_capable;
    logic xlate_fault;
  } dcbstl_req_t;

  // Command to the cache arrays and memory system
  typedef struct packed {
    logic valid;
    logic writeback;
    logic broadcast;
    logic fetch;
    logic lock;
    logic evict_locked;
    logic [1:0] level;
    logic [63:0] addr;
  } dcbstl_cmd_t;
endpackage

/* File: bench/dcbstl_assertions.sv */
// Checker for the block store, touch and lock engine
`timescale 1ns/1ps
`default_nettype none
module dcbstl_checker
  import dcbstl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pipeline and cache side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire dcbstl_req_t req,
  input wire dcbstl_cmd_t cmd,
  input wire logic cmd_done,
  input wire logic storage_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic acc = req_valid && req_ready;
  wire logic tch = acc && (req.op == OP_TOUCH || req.op == OP_TOUCH_ST);
  wire logic lck = acc && (req.op == OP_LOCK || req.op == OP_LOCK_ST);
  wire logic bad = req.inhibited || !req.lock_capable ||
    req.cache_target_field[0];
  //////////////////////////////////////////////////////////////////////////
  property p_store_wb;
    acc && req.op == OP_STORE && !req.xlate_fault |=>
      cmd.valid && cmd.writeback && !cmd.fetch;
  endproperty
  a_store_wb: assert property (p_store_wb)
    else $error("no writeback");
  property p_touch_inh;
    tch && req.inhibited |=> !cmd.valid && !storage_fault;
  endproperty
  a_touch_inh: assert property (p_touch_inh)
    else $error("touch not ignored");
  property p_touch_xf;
    tch && req.xlate_fault |=> !storage_fault && !cmd.valid;
  endproperty
  a_touch_xf: assert property (p_touch_xf)
    else $error("touch faulted");
  property p_touch_ct;
    tch && req.cache_target_field[0] |=> !cmd.valid;
  endproperty
  a_touch_ct: assert property (p_touch_ct)
    else $error("bad target acted");
  property p_lock_unable;
    lck && bad |=> !cmd.valid;
  endproperty
  a_lock_unable: assert property (p_lock_unable)
    else $error("lock not refused");
  property p_lock_xf;
    lck && req.xlate_fault |=> storage_fault ##1 !storage_fault;
  endproperty
  a_lock_xf: assert property (p_lock_xf)
    else $error("no lock fault");
  property p_hold;
    cmd.valid && !cmd_done |=> cmd.valid && $stable(cmd);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command dropped");
  property p_done_drop;
    cmd.valid && cmd_done |=> !cmd.valid ##[1:2] req_ready;
  endproperty
  a_done_drop: assert property (p_done_drop)
    else $error("no retire");
endmodule
bind dcbstl_engine dcbstl_checker dcbstl_checker_inst (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .cmd(cmd),
  .cmd_done(cmd_done), .storage_fault(storage_fault));
`default_nettype wire

/* File: bench/dcbstl_mem_model.sv */
// Cache array and memory stand-in answering commands
`timescale 1ns/1ps
`default_nettype none
module dcbstl_mem_model
  import dcbstl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command and completion
  input wire dcbstl_cmd_t cmd,
  input wire logic [3:0] lat,
  output logic cmd_done
);
  logic [3:0] cnt;
  //////////////////////////////////////////////////////////////////////////
  // Completion pulse lat+1 cycles into a held command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      cmd_done <= 1'b0;
    end else if (cmd_done || !cmd.valid) begin
      cnt <= 4'h0;
      cmd_done <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      cmd_done <= (cnt == lat);
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Testbench for the block store, touch and lock engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcbstl_pkg::*;
  logic clk, rst, req_valid, req_ready, line_hit, cmd_done, storage_fault;
  logic irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  dcbstl_req_t req;
  dcbstl_cmd_t cmd, cap;
  logic [3:0] way_locked, way_valid, cmd_way, capw, lat;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, mk;
  logic [1:0] bresp, rresp, rr;
  int mismatches, total_checks;
  dcbstl_engine #(.WAYS(4)) dcbstl_engine_inst (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .line_hit(line_hit), .line_dirty(1'b1), .way_locked(way_locked),
    .way_valid(way_valid), .cmd(cmd), .cmd_way(cmd_way), .cmd_done(cmd_done),
    .storage_fault(storage_fault), .irq(irq), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  dcbstl_mem_model dcbstl_mem_model_inst (.clk(clk), .rst(rst), .cmd(cmd),
    .lat(lat), .cmd_done(cmd_done));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits end only at the answer or at the watchdog
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    do begin
      @(posedge clk);
    end while (!bvalid);
    chk(bresp, RESP_OKAY);
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // One request: attributes {hit, inhibited, coherent, lockable, fault}
  task run(input dcbstl_op_t op, input logic [1:0] tgt, input logic [4:0] at,
      input logic [3:0] wl, input logic [7:0] ec, input logic es,
      input logic [2:0] est);
    @(posedge clk);
    req_valid <= 1'b1;
    req.op <= op;
    req.cache_target_field <= tgt;
    {line_hit, req.inhibited, req.coherent, req.lock_capable,
      req.xlate_fault} <= at;
    way_locked <= wl;
    do begin
      @(posedge clk);
    end while (!req_ready);
    req_valid <= 1'b0;
    @(posedge clk);
    cap = cmd;
    capw = cmd_way;
    chk(storage_fault, es);
    if (ec[7])
      chk({cap.valid, cap.writeback, cap.broadcast && op == OP_STORE,
        cap.fetch, cap.lock, cap.evict_locked, cap.level}, ec);
    else
      chk(cap.valid, 1'h0);
    do begin
      @(posedge clk);
    end while (!req_ready);
    axr(OFF_STAT, rd, rr);
    chk(rd[3:0], {1'h1, est});
    chk(irq, |({1'h1, est} & mk[3:0]));
    axw(OFF_STAT, 32'h0000_000F);
    chk(irq, 1'h0);
    $display("test op %0d target %0d done", op, tgt);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    mismatches++;
    summarize;
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {req_valid, line_hit, way_locked, lat, awaddr, araddr, wdata} = '0;
    mismatches = 0;
    total_checks = 0;
    mk = 32'h0;
    req = '0;
    way_valid = 4'hF;
    req.base = 64'h0000_0001_0000_1000;
    req.index = 64'h0000_0000_0000_0020;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axr(OFF_CTRL, rd, rr);
    chk(rd, 32'h0000_0038);
    axr(8'h0C, rd, rr);
    chk(rr, RESP_SLVERR);
    axw(OFF_CTRL, 32'h0000_003C);
    run(OP_STORE, 2'h0, 5'h06, 4'h0, 8'hE0, 1'h0, 3'h0);
    chk(cap.addr, 64'h0000_0000_0000_1020);
    req.base_zero <= 1'b1;
    run(OP_STORE, 2'h0, 5'h1A, 4'h0, 8'hC0, 1'h0, 3'h0);
    chk(cap.addr, 64'h0000_0000_0000_0020);
    run(OP_STORE, 2'h0, 5'h03, 4'h0, 8'h00, 1'h1, 3'h0);
    lat <= 4'h4;
    run(OP_TOUCH, 2'h1, 5'h06, 4'h0, 8'h00, 1'h0, 3'h0);
    run(OP_TOUCH_ST, 2'h0, 5'h0E, 4'h0, 8'h00, 1'h0, 3'h0);
    run(OP_TOUCH, 2'h0, 5'h07, 4'h0, 8'h00, 1'h0, 3'h0);
    run(OP_TOUCH_ST, 2'h0, 5'h06, 4'h1, 8'h90, 1'h0, 3'h0);
    chk(capw & 4'h1, 4'h0);
    way_valid <= 4'h7;
    run(OP_TOUCH_ST, 2'h0, 5'h06, 4'h1, 8'h90, 1'h0, 3'h0);
    chk(capw, 4'h8);
    way_valid <= 4'hF;
    run(OP_LOCK, 2'h1, 5'h06, 4'h0, 8'h00, 1'h0, 3'h1);
    axw(OFF_MASK, 32'h0000_0001);
    mk = 32'h0000_0001;
    run(OP_LOCK, 2'h0, 5'h06, 4'h3, 8'h98, 1'h0, 3'h0);
    chk(capw & 4'h3, 4'h0);
    run(OP_LOCK, 2'h0, 5'h16, 4'h0, 8'h88, 1'h0, 3'h0);
    run(OP_LOCK, 2'h0, 5'h0E, 4'h0, 8'h00, 1'h0, 3'h1);
    run(OP_LOCK_ST, 2'h0, 5'h04, 4'h0, 8'h00, 1'h0, 3'h1);
    run(OP_LOCK, 2'h0, 5'h07, 4'h0, 8'h00, 1'h1, 3'h0);
    run(OP_LOCK, 2'h0, 5'h06, 4'hF, 8'h00, 1'h0, 3'h2);
    axw(OFF_CTRL, 32'h0000_003D);
    run(OP_LOCK, 2'h0, 5'h06, 4'hF, 8'h9C, 1'h0, 3'h2);
    run(OP_LOCK_ST, 2'h2, 5'h06, 4'hF, 8'h00, 1'h0, 3'h4);
    axw(OFF_CTRL, 32'h0000_003E);
    run(OP_LOCK_ST, 2'h2, 5'h06, 4'hF, 8'h9E, 1'h0, 3'h4);
    axw(OFF_CTRL, 32'h0000_0034);
    run(OP_LOCK, 2'h0, 5'h06, 4'h0, 8'h00, 1'h0, 3'h1);
    summarize;
  end
endmodule
`default_nettype wire
